/* rtl/sirb_pkg.sv */
// sirb_pkg: constants and carrier types of the serial/ir banked registers
// assumes: a byte-wide register port with a three-bit offset
package sirb_pkg;
	// ------------------------------------------------------------
	// window offsets
	// ------------------------------------------------------------
	localparam logic [2:0] SIRB_OFF_00  = 3'h0;
	localparam logic [2:0] SIRB_OFF_01  = 3'h1;
	localparam logic [2:0] SIRB_OFF_02  = 3'h2;
	localparam logic [2:0] SIRB_OFF_SEL = 3'h3; // line control / bank select
	localparam logic [2:0] SIRB_OFF_04  = 3'h4;
	localparam logic [2:0] SIRB_OFF_06  = 3'h6;
	localparam logic [2:0] SIRB_OFF_07  = 3'h7;

	// ------------------------------------------------------------
	// bank selector fields
	// ------------------------------------------------------------
	localparam int         SIRB_BANK_BIT   = 7;  // byte is a bank code
	localparam logic [7:0] SIRB_CODE_BANK2 = 8'he0;
	localparam logic [7:0] SIRB_CODE_BANK3 = 8'he4;
	localparam logic [7:0] SIRB_CODE_BANK4 = 8'he8;
	localparam logic [7:0] SIRB_CODE_BANK5 = 8'hec;
	localparam logic [7:0] SIRB_CODE_BANK6 = 8'hf0;
	localparam logic [7:0] SIRB_CODE_BANK7 = 8'hf4;
	localparam logic [7:0] SIRB_LC_RESET   = 8'h00;
	localparam logic [7:0] SIRB_BS_RESET   = 8'h00;

	// ------------------------------------------------------------
	// identity and read-only defaults (values arbitrary)
	// ------------------------------------------------------------
	localparam logic [3:0] SIRB_MODULE_ID   = 4'h2; // arbitrary value
	localparam logic [3:0] SIRB_REVISION_ID = 4'h1; // arbitrary value
	localparam logic [7:0] SIRB_DEMOD_RESET = 8'h00;
	localparam logic [7:0] SIRB_MOD_RESET   = 8'h00;
	localparam logic [7:0] SIRB_CEIR_RESET  = 8'h00;

	// ------------------------------------------------------------
	// ir control field positions
	// ------------------------------------------------------------
	localparam int SIRB_IR_MODE_LSB  = 2;  // two-bit mode field
	localparam int SIRB_DUPLEX_BIT   = 0;  // full-duplex enable
	localparam int SIRB_LEVEL_W      = 5;  // fifo level count width

	// ------------------------------------------------------------
	// writable register table: bank, offset, writable mask
	// ------------------------------------------------------------
	localparam int SIRB_NREG = 13;
	typedef enum int {
		R_LDIV_L, R_LDIV_H, R_BDIV_L, R_BDIV_H, R_EXC1, R_EXC2,
		R_IRC1, R_IRC2, R_IRC3, R_PWID, R_CFG1, R_CFG3, R_CFG4
	} sirb_reg_idx_t;
	localparam logic [2:0] SIRB_REG_BANK [SIRB_NREG] = '{
		3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2,
		3'h4, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7, 3'h7};
	localparam logic [2:0] SIRB_REG_OFF [SIRB_NREG] = '{
		3'h0, 3'h1, 3'h0, 3'h1, 3'h2, 3'h4,
		3'h2, 3'h4, 3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
	localparam logic [7:0] SIRB_REG_MASK [SIRB_NREG] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'hd1, 8'hb0,
		8'h0c, 8'h0b, 8'hc0, 8'h0f, 8'hff, 8'h77, 8'hb8};
	localparam logic [7:0] SIRB_REG_RESET = 8'h00;

	// ------------------------------------------------------------
	// carrier of every table configuration byte to the port logic
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] legacy_divisor_low;
		logic [7:0] legacy_divisor_high;
		logic [7:0] baud_divisor_low;
		logic [7:0] baud_divisor_high;
		logic [7:0] extended_control_one;
		logic [7:0] extended_control_two;
		logic [7:0] ir_control_one;
		logic [7:0] ir_control_two;
		logic [7:0] ir_control_three;
		logic [7:0] slow_ir_pulse_width;
		logic [7:0] ir_interface_config_one;
		logic [7:0] ir_interface_config_three;
		logic [7:0] ir_interface_config_four;
	} sirb_cfg_t;
endpackage : sirb_pkg

/* rtl/sirb_regs.sv */
// sirb_regs: banked register file of the second serial port, banks 1-7
// assumes: host port synchronous to clk, strobes one cycle, never both
`timescale 1ns/1ns
module sirb_regs
	import sirb_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// host register port
	input  wire logic [2:0]              addr,
	input  wire logic [7:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [7:0]              rdata,
	// state reported by the port engines
	input  wire logic [SIRB_LEVEL_W-1:0] tx_level,
	input  wire logic [SIRB_LEVEL_W-1:0] rx_level,
	input  wire logic [7:0]              fifo_control,
	// configuration towards the port engines
	output sirb_cfg_t                    cfg,
	output logic [7:0]                   line_control,
	output logic [2:0]                   bank,
	output logic                         dma_dual
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] regs_q [SIRB_NREG]; // writable config bytes
	logic [7:0] lc_q;               // last line control byte
	logic [7:0] bs_q;               // last bank select byte, zero after a line control write
	logic [2:0] bank_q;             // decoded active bank
	logic [2:0] bank_d;             // bank from the new selector byte
	logic [7:0] rdata_q;            // read answer, one cycle
	logic [7:0] rdata_d;
	logic       dual_q;             // both dma channels in use
	logic       dual_d;

	// ------------------------------------------------------------
	// bank code decode
	// ------------------------------------------------------------
	// codes of the form 11xxxx00 that the table leaves out fall to
	// bank 1, so no code can leave the window unmapped
	function automatic logic [2:0] sirb_decode(input logic [7:0] c);
		logic [2:0] b;
		b = 3'h1;
		if (!c[7])                   b = 3'h0;
		else if (c == SIRB_CODE_BANK2) b = 3'h2;
		else if (c == SIRB_CODE_BANK3) b = 3'h3;
		else if (c == SIRB_CODE_BANK4) b = 3'h4;
		else if (c == SIRB_CODE_BANK5) b = 3'h5;
		else if (c == SIRB_CODE_BANK6) b = 3'h6;
		else if (c == SIRB_CODE_BANK7) b = 3'h7;
		return b;
	endfunction : sirb_decode

	// ------------------------------------------------------------
	// selector decode, common to every bank
	// ------------------------------------------------------------
	wire        sel_hit   = (addr == SIRB_OFF_SEL);
	wire        sel_wr    = wr && sel_hit;
	wire        bank_mode = wdata[SIRB_BANK_BIT];
	wire [7:0]  sel_rd    = bs_q[SIRB_BANK_BIT] ? bs_q : lc_q;
	assign bank_d = sirb_decode(wdata);

	// ------------------------------------------------------------
	// per-register decode; all banks share one window
	// ------------------------------------------------------------
	logic [SIRB_NREG-1:0] reg_hit;  // entry sits at addr in bank
	logic [7:0]           reg_rd [SIRB_NREG]; // masked read terms
	genvar gi;
	generate
		for (gi = 0; gi < SIRB_NREG; gi++) begin : g_reg
			assign reg_hit[gi] = (bank_q == SIRB_REG_BANK[gi]) &&
				(addr == SIRB_REG_OFF[gi]);
			assign reg_rd[gi] = reg_hit[gi] ? regs_q[gi] : 8'h00;
			// only the documented bits take a write
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					regs_q[gi] <= SIRB_REG_RESET;
				else if (wr && reg_hit[gi])
					regs_q[gi] <= wdata & SIRB_REG_MASK[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read-only terms of banks 2, 3 and 7
	// ------------------------------------------------------------
	wire b2_txl = (bank_q == 3'h2) && (addr == SIRB_OFF_06);
	wire b2_rxl = (bank_q == 3'h2) && (addr == SIRB_OFF_07);
	wire b3_id  = (bank_q == 3'h3) && (addr == SIRB_OFF_00);
	wire b3_slc = (bank_q == 3'h3) && (addr == SIRB_OFF_01);
	wire b3_sfc = (bank_q == 3'h3) && (addr == SIRB_OFF_02);
	wire b7_dmd = (bank_q == 3'h7) && (addr == SIRB_OFF_00);
	wire b7_mod = (bank_q == 3'h7) && (addr == SIRB_OFF_01);
	wire b7_cir = (bank_q == 3'h7) && (addr == SIRB_OFF_02);
	// level registers ignore writes: the engines own the counts
	wire [7:0] txl_byte = {3'h0, tx_level};
	wire [7:0] rxl_byte = {3'h0, rx_level};
	wire [7:0] id_byte  = {SIRB_MODULE_ID, SIRB_REVISION_ID};
	// shadow shows bank-select mode in bit 7, as the original
	wire [7:0] slc_byte = {bs_q[SIRB_BANK_BIT], lc_q[6:0]};

	// ------------------------------------------------------------
	// read multiplexer; no hit at all reads zero
	// ------------------------------------------------------------
	logic [7:0] reg_or;
	always_comb begin
		reg_or = 8'h00;
		for (int i = 0; i < SIRB_NREG; i++)
			reg_or = reg_or | reg_rd[i];
	end
	wire ro_hit = b2_txl | b2_rxl | b3_id | b3_slc | b3_sfc |
		b7_dmd | b7_mod | b7_cir;
	wire any_hit = sel_hit | ro_hit | (|reg_hit);
	wire [7:0] ro_or =
		({8{b2_txl}} & txl_byte) | ({8{b2_rxl}} & rxl_byte) |
		({8{b3_id}}  & id_byte)  | ({8{b3_slc}} & slc_byte) |
		({8{b3_sfc}} & fifo_control) |
		({8{b7_dmd}} & SIRB_DEMOD_RESET) |
		({8{b7_mod}} & SIRB_MOD_RESET) |
		({8{b7_cir}} & SIRB_CEIR_RESET);
	assign rdata_d = !rd ? 8'h00 :
		sel_hit ? sel_rd :
		any_hit ? (ro_or | reg_or) : 8'h00;

	// ------------------------------------------------------------
	// dma channel use: ir half duplex needs one, else both
	// ------------------------------------------------------------
	wire [1:0] ir_mode =
		regs_q[R_IRC1][SIRB_IR_MODE_LSB+1:SIRB_IR_MODE_LSB];
	wire       duplex  = regs_q[R_IRC2][SIRB_DUPLEX_BIT];
	assign dual_d = (ir_mode == 2'h0) || duplex;

	// ------------------------------------------------------------
	// selector and answer flops
	// ------------------------------------------------------------
	// a byte with bit 7 clear is line control and returns to bank 0;
	// a bank code leaves the line control bits untouched
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lc_q   <= SIRB_LC_RESET;
			bs_q   <= SIRB_BS_RESET;
			bank_q <= 3'h0;
		end else if (sel_wr) begin
			bank_q <= bank_d;
			if (bank_mode)
				bs_q <= wdata;
			else begin
				lc_q <= wdata;
				bs_q <= SIRB_BS_RESET;
			end
		end
	end

	// answer and dma flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
			dual_q  <= 1'b1;
		end else begin
			rdata_q <= rdata_d;
			dual_q  <= dual_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all from flops
	// ------------------------------------------------------------
	assign rdata        = rdata_q;
	assign line_control = lc_q;
	assign bank         = bank_q;
	assign dma_dual     = dual_q;
	assign cfg = '{
		legacy_divisor_low:        regs_q[R_LDIV_L],
		legacy_divisor_high:       regs_q[R_LDIV_H],
		baud_divisor_low:          regs_q[R_BDIV_L],
		baud_divisor_high:         regs_q[R_BDIV_H],
		extended_control_one:      regs_q[R_EXC1],
		extended_control_two:      regs_q[R_EXC2],
		ir_control_one:            regs_q[R_IRC1],
		ir_control_two:            regs_q[R_IRC2],
		ir_control_three:          regs_q[R_IRC3],
		slow_ir_pulse_width:       regs_q[R_PWID],
		ir_interface_config_one:   regs_q[R_CFG1],
		ir_interface_config_three: regs_q[R_CFG3],
		ir_interface_config_four:  regs_q[R_CFG4]};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_bank_zero_return: assert property (
		sel_wr && !wdata[7] |=> bank_q == 3'h0 ##1 1)
		else $error("line control write did not select bank 0");
	a_bank_two_code: assert property (
		sel_wr && wdata == 8'he0 |=> bank_q == 3'h2)
		else $error("code e0 did not select bank 2");
	a_bank_one_code: assert property (
		sel_wr && wdata[7:6] == 2'b10 |=> bank_q == 3'h1)
		else $error("code 10xxxxxx did not select bank 1");
	a_selector_read: assert property (
		rd && sel_hit |=>
		rdata == ($past(bs_q[7]) ? $past(bs_q) : $past(lc_q)))
		else $error("selector read wrong");
	a_tx_level_read: assert property (
		rd && bank_q == 3'h2 && addr == 3'h6 |=>
		rdata == {3'h0, $past(tx_level)})
		else $error("tx level read wrong");
	a_id_read: assert property (
		rd && bank_q == 3'h3 && addr == 3'h0 |=> rdata == id_byte)
		else $error("identifier read wrong");
	a_reserved_read: assert property (
		rd && !any_hit |=> rdata == 8'h00)
		else $error("reserved offset read not zero");
	a_reserved_write: assert property (
		wr && !any_hit |=> $stable(cfg) && $stable(lc_q))
		else $error("reserved write changed state");
	a_pulse_width: assert property (
		wr && bank_q == 3'h6 && addr == 3'h2 |=>
		cfg.slow_ir_pulse_width == {4'h0, $past(wdata[3:0])})
		else $error("pulse width write wrong");
	a_dma_dual: assert property (
		wr && bank_q == 3'h5 && addr == 3'h4 && wdata[0] |=>
		##1 dma_dual)
		else $error("full duplex did not take both channels");
	a_rdata_idle: assert property (
		!rd |=> rdata == 8'h00)
		else $error("read data outside answer cycle");

	// ------------------------------------------------------------
	// selector checks: table codes e4 to f4, and what a write keeps
	// ------------------------------------------------------------
	// the remaining table codes; a miss here strands the ir banks
	a_bank_three_code: assert property (
		sel_wr && wdata == SIRB_CODE_BANK3 |=> bank_q == 3'h3)
		else $error("code e4 did not select bank 3");
	a_bank_four_code: assert property (
		sel_wr && wdata == SIRB_CODE_BANK4 |=> bank_q == 3'h4)
		else $error("code e8 did not select bank 4");
	a_bank_five_code: assert property (
		sel_wr && wdata == SIRB_CODE_BANK5 |=> bank_q == 3'h5)
		else $error("code ec did not select bank 5");
	a_bank_six_code: assert property (
		sel_wr && wdata == SIRB_CODE_BANK6 |=> bank_q == 3'h6)
		else $error("code f0 did not select bank 6");
	a_bank_seven_code: assert property (
		sel_wr && wdata == SIRB_CODE_BANK7 |=> bank_q == 3'h7)
		else $error("code f4 did not select bank 7");
	// codes 11 with either low bit set stay in bank 1
	a_bank_one_low: assert property (
		sel_wr && wdata[7:6] == 2'b11 && wdata[1:0] != 2'b00 |=>
		bank_q == 3'h1)
		else $error("low-bit code did not select bank 1");
	// a bank code must not disturb the stored line format
	a_line_kept: assert property (
		sel_wr && wdata[7] |=> $stable(line_control))
		else $error("bank code changed line control");
	a_line_taken: assert property (
		sel_wr && !wdata[7] |=> line_control == $past(wdata))
		else $error("line control byte not stored");
	// only the selector moves the window
	a_bank_held: assert property (
		!sel_wr |=> $stable(bank_q))
		else $error("bank changed without a selector write");

	// ------------------------------------------------------------
	// write checks: ten of the bytes each land in their own cfg field
	// ------------------------------------------------------------
	// divisor bytes are independent; no pairing of low and high
	a_legacy_low: assert property (
		wr && bank_q == 3'h1 && addr == SIRB_OFF_00 |=>
		cfg.legacy_divisor_low == $past(wdata))
		else $error("legacy divisor low byte not stored");
	a_legacy_high: assert property (
		wr && bank_q == 3'h1 && addr == SIRB_OFF_01 |=>
		cfg.legacy_divisor_high == $past(wdata))
		else $error("legacy divisor high byte not stored");
	a_baud_low: assert property (
		wr && bank_q == 3'h2 && addr == SIRB_OFF_00 |=>
		cfg.baud_divisor_low == $past(wdata))
		else $error("baud divisor low byte not stored");
	a_baud_high: assert property (
		wr && bank_q == 3'h2 && addr == SIRB_OFF_01 |=>
		cfg.baud_divisor_high == $past(wdata))
		else $error("baud divisor high byte not stored");
	// reserved bits of the controls must read back zero
	a_ext_one: assert property (
		wr && bank_q == 3'h2 && addr == SIRB_OFF_02 |=>
		cfg.extended_control_one ==
		($past(wdata) & SIRB_REG_MASK[R_EXC1]))
		else $error("extended control one write wrong");
	a_ext_two: assert property (
		wr && bank_q == 3'h2 && addr == SIRB_OFF_04 |=>
		cfg.extended_control_two ==
		($past(wdata) & SIRB_REG_MASK[R_EXC2]))
		else $error("extended control two write wrong");
	a_ir_one: assert property (
		wr && bank_q == 3'h4 && addr == SIRB_OFF_02 |=>
		cfg.ir_control_one ==
		($past(wdata) & SIRB_REG_MASK[R_IRC1]))
		else $error("ir control one write wrong");
	a_ir_two: assert property (
		wr && bank_q == 3'h5 && addr == SIRB_OFF_04 |=>
		cfg.ir_control_two ==
		($past(wdata) & SIRB_REG_MASK[R_IRC2]))
		else $error("ir control two write wrong");
	a_ir_three: assert property (
		wr && bank_q == 3'h6 && addr == SIRB_OFF_00 |=>
		cfg.ir_control_three ==
		($past(wdata) & SIRB_REG_MASK[R_IRC3]))
		else $error("ir control three write wrong");
	a_ir_cfg_one: assert property (
		wr && bank_q == 3'h7 && addr == SIRB_OFF_04 |=>
		cfg.ir_interface_config_one ==
		($past(wdata) & SIRB_REG_MASK[R_CFG1]))
		else $error("ir interface config one write wrong");

	// ------------------------------------------------------------
	// read and refusal checks
	// ------------------------------------------------------------
	a_rx_level_read: assert property (
		rd && bank_q == 3'h2 && addr == SIRB_OFF_07 |=>
		rdata == {3'h0, $past(rx_level)})
		else $error("rx level read wrong");
	// the engines own the counts, so a level write is dropped
	a_level_write: assert property (
		wr && bank_q == 3'h2 && addr[2:1] == 2'b11 |=> $stable(cfg))
		else $error("level write changed state");
	a_shadow_line: assert property (
		rd && bank_q == 3'h3 && addr == SIRB_OFF_01 |=>
		rdata == {$past(bs_q[SIRB_BANK_BIT]), $past(lc_q[6:0])})
		else $error("line control shadow read wrong");
	a_shadow_fifo: assert property (
		rd && bank_q == 3'h3 && addr == SIRB_OFF_02 |=>
		rdata == $past(fifo_control))
		else $error("fifo control shadow read wrong");
	// no writer exists for these yet, so they read the reset value
	a_consumer_read: assert property (
		rd && bank_q == 3'h7 && addr == SIRB_OFF_02 |=>
		rdata == SIRB_CEIR_RESET)
		else $error("consumer ir config read wrong");
	a_ro_write: assert property (
		wr && ro_hit |=> $stable(cfg) && $stable(lc_q))
		else $error("read-only write changed state");

	// ------------------------------------------------------------
	// dma channel checks
	// ------------------------------------------------------------
	// the flag lags the ir control bytes by one cycle
	a_dma_single: assert property (
		cfg.ir_control_one[SIRB_IR_MODE_LSB+:2] != 2'h0 &&
		!cfg.ir_control_two[SIRB_DUPLEX_BIT] |=> !dma_dual)
		else $error("half duplex ir kept both dma channels");
	a_dma_uart: assert property (
		cfg.ir_control_one[SIRB_IR_MODE_LSB+:2] == 2'h0 |=> dma_dual)
		else $error("uart mode dropped a dma channel");

	c_bank_seven: cover property (sel_wr && wdata == 8'hf4);
	c_shadow_read: cover property (rd && b3_slc);
	c_single_dma: cover property ($fell(dma_dual));
	c_back_to_back: cover property (wr ##1 rd);
endmodule : sirb_regs

/* testbench/tb_top.sv */
// tb_top: self-checking bench of the banked serial/ir register file
// assumes: sirb_pkg and sirb_regs compiled first; one 25 MHz clock
`timescale 1ns/1ns
module tb_top;
	import sirb_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic                    clk = 1'b0;      // 25 mhz clock
	logic                    rst = 1'b1;      // async reset, active high
	logic      [2:0]         addr = 3'h0;     // window offset
	logic      [7:0]         wdata = 8'h00;   // write byte
	logic                    wr = 1'b0;       // write strobe
	logic                    rd = 1'b0;       // read strobe
	logic      [7:0]         rdata;           // read answer
	logic [SIRB_LEVEL_W-1:0] tx_level = 5'h00; // fill counts in
	logic [SIRB_LEVEL_W-1:0] rx_level = 5'h00;
	logic      [7:0]         fifo_control = 8'h00; // bank 0 fifo byte
	sirb_cfg_t               cfg;             // all writable table bytes
	logic      [7:0]         line_control;    // stored line control
	logic      [2:0]         bank;            // active bank
	logic                    dma_dual;        // both dma channels
	int                      n_errors = 0;
	int                      samples_checked = 0;
	logic      [7:0]         rb;              // last read byte
	// bank codes from the fixed table, 80 for bank 1; bank 0 is a plain line byte
	logic      [7:0]         code [8] = '{8'h00, 8'h80, SIRB_CODE_BANK2,
		SIRB_CODE_BANK3, SIRB_CODE_BANK4, SIRB_CODE_BANK5,
		SIRB_CODE_BANK6, SIRB_CODE_BANK7};

	always #20 clk = ~clk;

	sirb_regs DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .tx_level(tx_level),
		.rx_level(rx_level), .fifo_control(fifo_control), .cfg(cfg),
		.line_control(line_control), .bank(bank), .dma_dual(dma_dual));

	// ------------------------------------------------------------
	// bus cycles and comparison
	// ------------------------------------------------------------
	// returns just after the edge that took the write
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk) begin
			addr <= a; wdata <= d; wr <= 1'b1;
		end
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask : wr_reg
	// read data stand only in the cycle after the read edge
	task automatic rd_reg(input logic [2:0] a);
		@(posedge clk) begin
			addr <= a; rd <= 1'b1;
		end
		@(posedge clk) rd <= 1'b0;
		#1 rb = rdata;
	endtask : rd_reg
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic sel(input int b);
		wr_reg(SIRB_OFF_SEL, code[b]);
	endtask : sel

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// outputs straight after reset
	task automatic t_reset();
		chk(rdata, 8'h00);
		chk({5'h00, bank}, 8'h00);
		chk(line_control, SIRB_LC_RESET);
		chk({7'h00, dma_dual}, 8'h01);
		chk({7'h00, |cfg}, 8'h00);
		$display("test reset done");
	endtask : t_reset
	// every table bank code, plus six codes off the table
	task automatic t_codes();
		logic [7:0] c [12] = '{8'h80, 8'hbf, 8'hc2, 8'hc1, 8'hc0,
			8'hfc, 8'he0, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4};
		logic [2:0] b [12] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
			3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		for (int i = 0; i < 12; i++) begin
			wr_reg(SIRB_OFF_SEL, c[i]);
			chk({5'h00, bank}, {5'h00, b[i]});
			rd_reg(SIRB_OFF_SEL);
			chk(rb, c[i]);
		end
		$display("test codes done");
	endtask : t_codes
	// line control write, then shadows and ids in bank 3
	task automatic t_shadow();
		wr_reg(SIRB_OFF_SEL, 8'h5b);
		chk({5'h00, bank}, 8'h00);
		chk(line_control, 8'h5b);
		@(posedge clk) fifo_control <= 8'hc7;
		sel(3);
		chk(line_control, 8'h5b);
		rd_reg(SIRB_OFF_00);
		chk(rb, {SIRB_MODULE_ID, SIRB_REVISION_ID});
		rd_reg(SIRB_OFF_01);
		chk(rb, 8'hdb);
		rd_reg(SIRB_OFF_02);
		chk(rb, 8'hc7);
		wr_reg(SIRB_OFF_01, 8'h00);
		rd_reg(SIRB_OFF_01);
		chk(rb, 8'hdb);
		$display("test shadow done");
	endtask : t_shadow
	// each writable register: all ones then zeros back
	task automatic t_table();
		int p; // bit position of entry i in cfg
		for (int i = 0; i < SIRB_NREG; i++) begin
			p = 8 * (SIRB_NREG - 1 - i);
			sel(int'(SIRB_REG_BANK[i]));
			wr_reg(SIRB_REG_OFF[i], 8'hff);
			rd_reg(SIRB_REG_OFF[i]);
			chk(rb, SIRB_REG_MASK[i]);
			chk(cfg[p +: 8], SIRB_REG_MASK[i]);
			wr_reg(SIRB_REG_OFF[i], 8'h00);
			rd_reg(SIRB_REG_OFF[i]);
			chk(rb, SIRB_REG_RESET);
			chk(cfg[p +: 8], SIRB_REG_RESET);
		end
		$display("test table done");
	endtask : t_table
	// fifo levels are live and ignore writes; rdata drops after
	task automatic t_levels();
		sel(2);
		@(posedge clk) tx_level <= 5'h15;
		rx_level <= 5'h0a;
		wr_reg(SIRB_OFF_06, 8'hff);
		rd_reg(SIRB_OFF_06);
		chk(rb, 8'h15);
		rd_reg(SIRB_OFF_07);
		chk(rb, 8'h0a);
		@(posedge clk) #1;
		chk(rdata, 8'h00);
		$display("test levels done");
	endtask : t_levels
	// reserved and read-only places read zero, keep state
	task automatic t_reserved();
		logic [2:0] rb_bank [10] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
			3'h6, 3'h7, 3'h7, 3'h7};
		logic [2:0] rb_off  [10] = '{3'h2, 3'h7, 3'h5, 3'h5, 3'h0, 3'h6,
			3'h1, 3'h0, 3'h1, 3'h2};
		for (int i = 0; i < 10; i++) begin
			sel(int'(rb_bank[i]));
			wr_reg(rb_off[i], 8'hff);
			rd_reg(rb_off[i]);
			chk(rb, 8'h00);
			chk({7'h00, |cfg}, 8'h00);
		end
		$display("test reserved done");
	endtask : t_reserved
	// dual dma follows ir mode and full duplex, one cycle after the write
	task automatic t_dma();
		sel(4);
		wr_reg(SIRB_OFF_02, 8'h04);
		@(posedge clk) #1;
		chk({7'h00, dma_dual}, 8'h00);
		sel(5);
		wr_reg(SIRB_OFF_04, 8'h01);
		@(posedge clk) #1;
		chk({7'h00, dma_dual}, 8'h01);
		$display("test dma done");
	endtask : t_dma
	// a reset in mid-run must clear every byte and the selector
	task automatic t_rerun();
		wr_reg(SIRB_OFF_04, 8'h00);
		@(posedge clk) #1;
		chk({7'h00, dma_dual}, 8'h00);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(rdata, 8'h00);
		chk({5'h00, bank}, 8'h00);
		chk({7'h00, |cfg}, 8'h00);
		chk({7'h00, dma_dual}, 8'h01);
		rd_reg(SIRB_OFF_SEL);
		chk(rb, SIRB_LC_RESET);
		$display("test rerun done");
	endtask : t_rerun

	// ------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic results();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	// the whole run needs well under a thousand cycles
	initial begin
		#(40 * 6000);
		n_errors++;
		$display("watchdog expired");
		results();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_codes();
		t_shadow();
		t_table();
		t_levels();
		t_reserved();
		t_dma();
		t_rerun();
		results();
	end
endmodule : tb_top
